// ==== qss_pkg.sv ====
package qss_pkg;

  localparam int unsigned AXI_AW = 6;
  localparam int unsigned SYM_W = 8;
  localparam int unsigned IQ_W = 5;
  localparam int unsigned MARK_W = 9;
  localparam int unsigned LIST_DEPTH_DEF = 256;
  localparam int unsigned FIFO_DEPTH_DEF = 32;

  localparam logic [AXI_AW-1:0] OFF_CTRL = 6'h00;
  localparam logic [AXI_AW-1:0] OFF_BAUD = 6'h04;
  localparam logic [AXI_AW-1:0] OFF_MARK = 6'h08;
  localparam logic [AXI_AW-1:0] OFF_DATA = 6'h0C;
  localparam logic [AXI_AW-1:0] OFF_STAT = 6'h10;

  localparam int unsigned CTRL_CARRIER_BIT = 0;
  localparam int unsigned CTRL_TYPE_LSB = 1;
  localparam int unsigned CTRL_CLEAR_BIT = 8;
  localparam int unsigned STAT_LEN_LSB = 0;
  localparam int unsigned STAT_POS_LSB = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic CARRIER_RST = 1'b1;

  // Symbol rate is held in units of 1/8 Hz so that 0.125 Hz to 500 MHz fits in 32 bits.
  localparam logic [31:0] CLK_HZ = 32'h02625A00;
  localparam logic [31:0] BAUD_UNITS_PER_HZ = 32'h00000008;
  localparam logic [31:0] BAUD_DEF_HZ = 32'h00002710;
  localparam logic [31:0] BAUD_RST = 32'(BAUD_DEF_HZ * BAUD_UNITS_PER_HZ);
  localparam logic [31:0] BAUD_MIN = 32'h00000001;
  localparam logic [31:0] BAUD_MAX = 32'hEE6B2800;
  localparam logic [32:0] BAUD_MOD = 33'({1'b0, CLK_HZ} * {1'b0, BAUD_UNITS_PER_HZ});

  localparam logic [MARK_W-1:0] MARK_MIN = 9'h001;
  localparam logic [MARK_W-1:0] MARK_MAX = 9'h100;
  localparam logic [MARK_W-1:0] MARK_RST = 9'h001;

  typedef enum logic [1:0] {
    QSS_QAM16 = 2'h0,
    QSS_QAM64 = 2'h1,
    QSS_QAM256 = 2'h2
  } qss_qam_t;

  localparam qss_qam_t TYPE_RST = QSS_QAM16;

  function automatic logic [31:0] qss_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Leading two bits pick the quadrant, the rest split evenly into I and Q levels.
  function automatic logic [2*IQ_W-1:0] qss_map(input logic [SYM_W-1:0] w, input qss_qam_t t);
    logic [1:0] quad;
    logic [2:0] ip;
    logic [2:0] qp;
    logic [IQ_W-1:0] mi;
    logic [IQ_W-1:0] mq;
    quad = w[7:6];
    ip = w[5:3];
    qp = w[2:0];
    unique case (t)
      QSS_QAM16: begin
        quad = w[3:2];
        ip = {2'h0, w[1]};
        qp = {2'h0, w[0]};
      end
      QSS_QAM64: begin
        quad = w[5:4];
        ip = {1'h0, w[3:2]};
        qp = {1'h0, w[1:0]};
      end
      QSS_QAM256: begin
        quad = w[7:6];
        ip = w[5:3];
        qp = w[2:0];
      end
    endcase
    mi = {1'b0, ip, 1'b1};
    mq = {1'b0, qp, 1'b1};
    if (quad[1] ^ quad[0]) begin
      mi = 5'h00 - mi;
    end
    if (quad[1]) begin
      mq = 5'h00 - mq;
    end
    return {mi, mq};
  endfunction

endpackage

// ==== qss_stream_if.sv ====
`timescale 1ns/10ps
interface qss_stream_if #(parameter int unsigned W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport tx(output valid, output data, input ready);
  modport rx(input valid, input data, output ready);
endinterface

// ==== qss_fifo.sv ====
`timescale 1ns/10ps
module qss_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  qss_stream_if.rx in_s,
  qss_stream_if.tx out_s
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;

  wire push = in_s.valid & in_s.ready;
  wire pop = out_s.valid & out_s.ready;

  assign in_s.ready = (count_r != CW'(DEPTH));
  assign out_s.valid = (count_r != '0);
  assign out_s.data = mem[rd_ptr_r];

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_s.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= bump(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= bump(rd_ptr_r);
      end
      count_r <= CW'(count_r + CW'(push) - CW'(pop));
    end
  end
endmodule

// ==== qss_top.sv ====
`timescale 1ns/10ps
// Functional notes
// R1 - Symbol rate accepts 0.1 Hz to 500 MHz, resets to 10 kHz; the code's lowest rate is 0.125 Hz (one 1/8 Hz unit).
// R2 - Baud generator strobe alone advances the symbol list.
// R3 - Carrier enable defaults on; off gives baseband only; reads back 1 or 0.
// R4 - Symbol word is four bits for 16QAM, eight bits for 256QAM.
// R5 - Host supplies symbol words grouped to the selected type's width.
// R6 - Vectors leave in list order, one per symbol period, first entry first.
// R7 - Marker pulse on sync at programmed index, 1 to 256, default 1.
// R8 - Host sets marker before loading; later changes wait for next load.
// R9 - One marker index serves every modulation type.
// R10 - Marker index reads back exactly as programmed.
// R11 - Two leading bits choose quadrant; remaining bits choose point.
// R12 - 64QAM word is six bits: two quadrant bits, four position bits.
// R13 - After the last entry the list wraps to the first and continues.
module qss_top
  import qss_pkg::*;
#(
  parameter int unsigned LIST_DEPTH = LIST_DEPTH_DEF,
  parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [AXI_AW-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [AXI_AW-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  output logic [IQ_W-1:0] SYM_I,
  output logic [IQ_W-1:0] SYM_Q,
  output logic SYM_STROBE,
  output logic SYNC_MARK,
  output logic CARRIER_WAVE_EN
);
  localparam int unsigned LW = $clog2(LIST_DEPTH + 1);
  localparam int unsigned IW = $clog2(LIST_DEPTH);

  qss_stream_if #(.W(SYM_W)) load_s ();
  qss_stream_if #(.W(SYM_W)) drain_s ();

  qss_fifo #(.W(SYM_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_s(load_s.rx),
    .out_s(drain_s.tx)
  );

  // Write channel state.
  logic aw_have_r;
  logic w_have_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic [AXI_AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  // Read channel state.
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;

  // Settings.
  logic carrier_r;
  qss_qam_t type_r;
  logic [31:0] baud_r;
  logic [MARK_W-1:0] mark_r;
  logic [MARK_W-1:0] mark_act_r;

  // Sequencer state.
  logic [SYM_W-1:0] list_mem [LIST_DEPTH];
  logic [LW-1:0] len_r;
  logic [IW-1:0] rd_idx_r;
  logic [MARK_W-1:0] pos_r;
  logic [32:0] acc_r;
  logic [IQ_W-1:0] sym_i_r;
  logic [IQ_W-1:0] sym_q_r;
  logic strobe_r;
  logic mark_out_r;

  // Write path decode.
  wire aw_take = AWVALID & awready_r;
  wire w_take = WVALID & wready_r;
  wire wr_is_ctrl = (awaddr_r == OFF_CTRL);
  wire wr_is_baud = (awaddr_r == OFF_BAUD);
  wire wr_is_mark = (awaddr_r == OFF_MARK);
  wire wr_is_data = (awaddr_r == OFF_DATA);
  wire wr_known = wr_is_ctrl | wr_is_baud | wr_is_mark | wr_is_data;
  wire wr_both = aw_have_r & w_have_r & ~bvalid_r;
  // A symbol write waits here while the load FIFO is full, which stalls the bus.
  wire wr_push = wr_both & wr_is_data & wstrb_r[0];
  wire wr_go = wr_both & ~(wr_push & ~load_s.ready);
  wire aw_have_nxt = (aw_have_r | aw_take) & ~wr_go;
  wire w_have_nxt = (w_have_r | w_take) & ~wr_go;
  wire bvalid_nxt = (bvalid_r & ~BREADY) | wr_go;

  wire [31:0] ctrl_now = {23'h000000, 1'b0, 5'h00, type_r, carrier_r};
  wire [31:0] ctrl_new = qss_merge(ctrl_now, wdata_r, wstrb_r);
  wire [31:0] baud_new = qss_merge(baud_r, wdata_r, wstrb_r);
  wire [31:0] mark_new = qss_merge({23'h000000, mark_r}, wdata_r, wstrb_r);
  wire [1:0] type_req = ctrl_new[CTRL_TYPE_LSB +: 2];
  wire ctrl_wr = wr_go & wr_is_ctrl;
  wire type_ok = (type_req != 2'h3);
  wire baud_ok = (baud_new >= BAUD_MIN) & (baud_new <= BAUD_MAX);
  wire mark_ok = (mark_new >= {23'h000000, MARK_MIN}) & (mark_new <= {23'h000000, MARK_MAX});
  wire list_clear = ctrl_wr & ctrl_new[CTRL_CLEAR_BIT];

  assign load_s.valid = wr_push;
  assign load_s.data = wdata_r[SYM_W-1:0];

  // Read path decode.
  wire ar_take = ARVALID & arready_r;
  wire rvalid_nxt = (rvalid_r & ~RREADY) | ar_take;
  wire rd_is_ctrl = (ARADDR == OFF_CTRL);
  wire rd_is_baud = (ARADDR == OFF_BAUD);
  wire rd_is_mark = (ARADDR == OFF_MARK);
  wire rd_is_data = (ARADDR == OFF_DATA);
  wire rd_is_stat = (ARADDR == OFF_STAT);
  wire rd_known = rd_is_ctrl | rd_is_baud | rd_is_mark | rd_is_data | rd_is_stat;
  wire [31:0] stat_word = {16'(pos_r), 16'(len_r)};
  wire [31:0] rd_word = rd_is_ctrl ? ctrl_now :
                        rd_is_baud ? baud_r :
                        rd_is_mark ? {23'h000000, mark_r} :
                        rd_is_stat ? stat_word : 32'h00000000;

  // Baud generator: accumulate the rate and strobe on each wrap of the clock modulus.
  wire [32:0] acc_sum = 33'(acc_r + {1'b0, baud_r});
  wire baud_hit = (acc_sum >= BAUD_MOD);
  wire [32:0] acc_sub = 33'(acc_sum - BAUD_MOD);
  wire [32:0] acc_nxt = !baud_hit ? acc_sum : ((acc_sub >= BAUD_MOD) ? 33'h000000000 : acc_sub);

  // Sequencer decode.
  wire step = baud_hit & (len_r != '0) & ~list_clear;
  wire [IW-1:0] rd_idx_nxt = (LW'(rd_idx_r) == LW'(len_r - 1'b1)) ? '0 : IW'(rd_idx_r + 1'b1);
  wire [MARK_W-1:0] entry_pos = MARK_W'(rd_idx_r) + 9'h001;
  wire [2*IQ_W-1:0] iq_word = qss_map(list_mem[rd_idx_r], type_r);
  wire drain_go = drain_s.valid & drain_s.ready;

  assign drain_s.ready = (len_r != LW'(LIST_DEPTH)) & ~list_clear;

  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awready_r <= ~aw_have_nxt & ~bvalid_nxt;
      wready_r <= ~w_have_nxt & ~bvalid_nxt;
      bvalid_r <= bvalid_nxt;
      if (wr_go) begin
        bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (aw_take) begin
      awaddr_r <= AWADDR;
    end
    if (w_take) begin
      wdata_r <= WDATA;
      wstrb_r <= WSTRB;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_take) begin
        rresp_r <= rd_known ? RESP_OKAY : RESP_SLVERR;
        rdata_r <= rd_word; // R3 R10
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      carrier_r <= CARRIER_RST; // R3
      type_r <= TYPE_RST;
      baud_r <= BAUD_RST; // R1
      mark_r <= MARK_RST; // R7
    end else begin
      if (ctrl_wr) begin
        carrier_r <= ctrl_new[CTRL_CARRIER_BIT]; // R3
      end
      if (ctrl_wr & type_ok) begin
        type_r <= qss_qam_t'(type_req); // R4
      end
      if (wr_go & wr_is_baud & baud_ok) begin
        baud_r <= baud_new; // R1
      end
      if (wr_go & wr_is_mark & mark_ok) begin
        mark_r <= mark_new[MARK_W-1:0]; // R7 R10
      end
    end
  end

  // The marker in force is captured when a new list is started, not when the index is written.
  always_ff @(posedge CLK) begin
    if (RST) begin
      mark_act_r <= MARK_RST;
    end else if (list_clear) begin
      mark_act_r <= mark_r; // R8 R9
    end
  end

  always_ff @(posedge CLK) begin
    if (drain_go) begin
      list_mem[IW'(len_r)] <= drain_s.data; // R5
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      len_r <= '0;
    end else if (list_clear) begin
      len_r <= '0;
    end else if (drain_go) begin
      len_r <= LW'(len_r + 1'b1);
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || list_clear) begin
      acc_r <= 33'h000000000;
    end else begin
      acc_r <= acc_nxt; // R1 R2
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || list_clear) begin
      rd_idx_r <= '0; // R6
      pos_r <= 9'h000;
    end else if (step) begin
      rd_idx_r <= rd_idx_nxt; // R2 R13
      pos_r <= entry_pos;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      sym_i_r <= 5'h00;
      sym_q_r <= 5'h00;
      strobe_r <= 1'b0;
      mark_out_r <= 1'b0;
    end else begin
      strobe_r <= step; // R2 R6
      mark_out_r <= step & (entry_pos == mark_act_r); // R7 R9
      if (step) begin
        sym_i_r <= iq_word[IQ_W +: IQ_W]; // R11 R12 R4
        sym_q_r <= iq_word[0 +: IQ_W]; // R11 R12
      end
    end
  end

  assign AWREADY = awready_r;
  assign WREADY = wready_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign ARREADY = arready_r;
  assign RVALID = rvalid_r;
  assign RRESP = rresp_r;
  assign RDATA = rdata_r;
  assign SYM_I = sym_i_r;
  assign SYM_Q = sym_q_r;
  assign SYM_STROBE = strobe_r;
  assign SYNC_MARK = mark_out_r;
  assign CARRIER_WAVE_EN = carrier_r;
endmodule

// ==== qss_top_chk.sv ====
`timescale 1ns/10ps
module qss_top_chk
  import qss_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic AWREADY,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [IQ_W-1:0] SYM_I,
  input wire logic [IQ_W-1:0] SYM_Q,
  input wire logic SYM_STROBE,
  input wire logic SYNC_MARK,
  input wire logic CARRIER_WAVE_EN
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  AST_SYNC_WITH_STROBE: assert property (SYNC_MARK |-> SYM_STROBE)
    else $error("sync marker without symbol strobe");
  AST_VECTOR_HELD: assert property (!SYM_STROBE |-> $stable({SYM_I, SYM_Q}))
    else $error("vector changed without strobe");
  AST_LEVEL_ODD: assert property (SYM_STROBE |-> SYM_I[0] && SYM_Q[0])
    else $error("vector level not odd");
  AST_CARRIER_RESET: assert property ($past(RST) |-> CARRIER_WAVE_EN)
    else $error("carrier not on after reset");
  AST_READ_ANSWER: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read answer late");
  AST_READ_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data not held");
  AST_WRITE_HOLD: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response not held");
  AST_WRITE_BLOCK: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response pending");
endmodule

bind qss_top qss_top_chk u_chk (.CLK(CLK), .RST(RST), .AWREADY(AWREADY), .WREADY(WREADY), .BRESP(BRESP),
  .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID),
  .RREADY(RREADY), .SYM_I(SYM_I), .SYM_Q(SYM_Q), .SYM_STROBE(SYM_STROBE), .SYNC_MARK(SYNC_MARK),
  .CARRIER_WAVE_EN(CARRIER_WAVE_EN));

// ==== qss_sink_model.sv ====
`timescale 1ns/10ps
module qss_sink_model
  import qss_pkg::*;
(
  input wire logic clk,
  input wire logic clr,
  input wire logic [IQ_W-1:0] sym_i,
  input wire logic [IQ_W-1:0] sym_q,
  input wire logic strobe,
  input wire logic mark
);
  // Records up to 16 vectors the output stage takes after a clear, with its marker and the cycles since the one before.
  logic [2*IQ_W:0] ent [16];
  int gap [16];
  int cnt = 0;
  int since = 0;
  always @(posedge clk) begin
    since <= since + 1;
    if (clr) begin
      cnt <= 0;
    end else if (strobe && cnt < 16) begin
      ent[cnt] <= {mark, sym_i, sym_q};
      gap[cnt] <= since;
      cnt <= cnt + 1;
      since <= 1;
    end
  end
endmodule

// ==== qam_symbol_sequencer_bench.sv ====
`timescale 1ns/10ps
module qam_symbol_sequencer_bench;
  import qss_pkg::*;
  logic CLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, sink_clr;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SYM_STROBE, SYNC_MARK, CARRIER_WAVE_EN;
  logic [AXI_AW-1:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rd_v;
  logic [1:0] BRESP, RRESP, rsp;
  logic [IQ_W-1:0] SYM_I, SYM_Q;
  logic [7:0] words [4];
  int bad_count = 0;
  int num_checks = 0;

  qss_top dut (.CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWPROT(3'h0), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(3'h0), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .SYM_I(SYM_I), .SYM_Q(SYM_Q), .SYM_STROBE(SYM_STROBE),
    .SYNC_MARK(SYNC_MARK), .CARRIER_WAVE_EN(CARRIER_WAVE_EN));
  qss_sink_model sink (.clk(CLK), .clr(sink_clr), .sym_i(SYM_I), .sym_q(SYM_Q), .strobe(SYM_STROBE),
    .mark(SYNC_MARK));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic timeout();
    bad_count++;
    $display("wait limit reached");
    conclude();
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID) break;
    end
    rsp = BRESP;
    BREADY <= 1'b0;
    if (n == 99) timeout();
  endtask

  task automatic rd(input logic [5:0] a);
    int n;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID) break;
    end
    rd_v = RDATA;
    rsp = RRESP;
    RREADY <= 1'b0;
    if (n == 99) timeout();
  endtask

  // Independent reading of the mapping: two quadrant bits on top, then equal I and Q fields.
  function automatic logic [9:0] exp_iq(input int t, input int w);
    int nb, m, vi, vq, q;
    nb = t + 1;
    m = (1 << nb) - 1;
    vi = 2 * ((w >> nb) & m) + 1;
    vq = 2 * (w & m) + 1;
    q = (w >> (2 * nb)) & 3;
    if (q == 1 || q == 2) vi = -vi;
    if (q >= 2) vq = -vq;
    return {5'(vi), 5'(vq)};
  endfunction

  initial begin
    int n, nb;
    RST = 1'b1;
    AWVALID = 1'b0;
    WVALID = 1'b0;
    BREADY = 1'b0;
    ARVALID = 1'b0;
    RREADY = 1'b0;
    AWADDR = '0;
    ARADDR = '0;
    WDATA = '0;
    sink_clr = 1'b0;
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    rd(OFF_CTRL);
    chk("ctrl reset", rd_v, 32'h00000001);
    rd(OFF_BAUD);
    chk("baud reset", rd_v, 32'h00013880);
    rd(OFF_MARK);
    chk("mark reset", rd_v, 32'h00000001);
    rd(6'h14);
    chk("unmapped read resp", 32'(rsp), 32'(RESP_SLVERR));
    chk("unmapped read data", rd_v, 32'h00000000);
    wr(OFF_STAT, 32'h00000000);
    chk("status write resp", 32'(rsp), 32'(RESP_SLVERR));
    wr(OFF_MARK, 32'h00000100);
    wr(OFF_MARK, 32'h00000000);
    rd(OFF_MARK);
    chk("mark top", rd_v, 32'h00000100);
    wr(OFF_BAUD, 32'hEE6B2800);
    wr(OFF_BAUD, 32'hEE6B2801);
    rd(OFF_BAUD);
    chk("baud top", rd_v, 32'hEE6B2800);
    $display("test registers done");
    wr(OFF_CTRL, 32'h00000000);
    chk("carrier off pin", 32'(CARRIER_WAVE_EN), 32'h0);
    rd(OFF_CTRL);
    chk("carrier off read", rd_v, 32'h00000000);
    wr(OFF_CTRL, 32'h00000007);
    chk("carrier on pin", 32'(CARRIER_WAVE_EN), 32'h1);
    rd(OFF_CTRL);
    chk("type code 3 ignored", rd_v, 32'h00000001);
    $display("test carrier done");
    for (int t = 0; t < 3; t++) begin
      nb = t + 1;
      for (int k = 0; k < 4; k++) begin
        words[k] = 8'((k << (2 * nb)) | (((k + 1) & ((1 << nb) - 1)) << nb) | ((3 - k) & ((1 << nb) - 1)));
      end
      wr(OFF_BAUD, 32'h00000001);
      wr(OFF_MARK, 32'h00000003);
      wr(OFF_CTRL, 32'h00000101 | 32'(t << 1));
      for (int k = 0; k < 4; k++) wr(OFF_DATA, 32'(words[k]));
      wr(OFF_MARK, 32'h00000002);
      repeat (4) @(posedge CLK);
      rd(OFF_STAT);
      chk("list length", rd_v, 32'h00000004);
      rd(OFF_CTRL);
      chk("type readback", rd_v, 32'h00000001 | 32'(t << 1));
      rd(OFF_MARK);
      chk("mark readback", rd_v, 32'h00000002);
      sink_clr <= 1'b1;
      @(posedge CLK);
      sink_clr <= 1'b0;
      wr(OFF_BAUD, 32'h04C4B400);
      for (n = 0; n < 200 && sink.cnt < 6; n++) @(posedge CLK);
      if (n == 200) timeout();
      for (int k = 0; k < 6; k++) begin
        chk("vector", 32'(sink.ent[k][9:0]), 32'(exp_iq(t, words[k % 4])));
        chk("sync", 32'(sink.ent[k][10]), 32'(k % 4 == 2));
        if (k > 0) chk("strobe spacing", 32'(sink.gap[k]), 32'h4);
      end
      $display("test stream type %0d done", t);
    end
    conclude();
  end
endmodule
